// >>> itmr_consts.svh
// Purpose: named offsets, field positions, reset values and counts of the interval timer
// Assumes: word-addressed register port, 16-bit data, 32-bit counter
// Notes: definitions only, included by the package users
`ifndef ITMR_CONSTS_SVH
`define ITMR_CONSTS_SVH

// ----------------------------------------------------------------
// register word offsets
// ----------------------------------------------------------------
`define ITMR_OFS_FLAGS 3'h0
`define ITMR_OFS_CTRL 3'h1
`define ITMR_OFS_RLDL 3'h2
`define ITMR_OFS_RLDH 3'h3
`define ITMR_OFS_CAPL 3'h4
`define ITMR_OFS_CAPH 3'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ITMR_FLG_TO 0
`define ITMR_FLG_RUN 1
`define ITMR_CTL_IEN 0
`define ITMR_CTL_CONTINUOUS_MODE 1
`define ITMR_CTL_START 2
`define ITMR_CTL_STOP 3

// ----------------------------------------------------------------
// reset values and counting constants
// ----------------------------------------------------------------
`define ITMR_RELOAD_RST 32'h0000_ffff
`define ITMR_CAPTURE_RST 32'h0000_0000
`define ITMR_WORD_RST 16'h0000
`define ITMR_CNT_ZERO 32'h0000_0000
`define ITMR_CNT_ONE 32'h0000_0001

`endif

// >>> itmr_counter.sv
// Purpose: 32-bit down counter with run control and reload at zero
// Assumes: commands come from the register file one cycle wide
// Notes: load beats the zero reload; halt beats start
`include "itmr_consts.svh"

module itmr_counter #(
   parameter bit STOPCTL_EN = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input itmr_pkg::itmr_cmd_s cmd_i,
   input wire logic continuous_mode_i,
   input itmr_pkg::itmr_cnt_t reload_i,
   output itmr_pkg::itmr_cnt_st_s st_o,
   output logic zero_o
);

   localparam itmr_pkg::itmr_cnt_st_s RST_ST = '{count: `ITMR_RELOAD_RST, run: !STOPCTL_EN};

   itmr_pkg::itmr_cnt_st_s st_q;
   itmr_pkg::itmr_cnt_st_s st_d;

   assign zero_o = st_q.run && (st_q.count == `ITMR_CNT_ZERO);
   assign st_o = st_q;

   // next counter state
   always_comb begin
      st_d = st_q;
      if (st_q.run) begin
         if (zero_o) begin
            st_d.count = reload_i;
            if (STOPCTL_EN && !continuous_mode_i) begin
               st_d.run = 1'b0;
            end
         end else begin
            st_d.count = st_q.count - `ITMR_CNT_ONE;
         end
      end
      // start wakes stopped counter only, so a one-shot zero still stops
      if (cmd_i.start && !st_q.run) begin
         st_d.run = 1'b1;
      end
      if (STOPCTL_EN && cmd_i.halt) begin
         st_d.run = 1'b0;
      end
      if (cmd_i.load) begin
         st_d.count = cmd_i.load_val;
      end
      if (!STOPCTL_EN) begin
         st_d.run = 1'b1; // no run control: always counting
      end
   end

   // state register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= RST_ST;
      end else begin
         st_q <= st_d;
      end
   end

endmodule : itmr_counter

// >>> itmr_master.sv
// Purpose: bus master model for the interval timer register port
// Assumes: one access at a time, strobes launched just after a rising edge
// Notes: the testbench calls wr_reg and rd_reg through the instance
`include "itmr_consts.svh"

module itmr_master (
   input wire logic clk_i,
   output logic cs_o,
   output logic wr_o,
   output logic rd_o,
   output logic [2:0] addr_o,
   output itmr_pkg::itmr_word_t wdata_o,
   input wire logic [15:0] rdata_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // bus cycles
   // ----------------------------------------------------------------
   // idle bus at time zero
   initial begin
      cs_o = 1'b0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 3'h0;
      wdata_o = 16'h0000;
   end

   // one strobe cycle; released lines show the inverse so stale data never matches
   task automatic cycle(input logic w, input logic [2:0] a, input itmr_pkg::itmr_word_t d);
      @(posedge clk_i);
      cs_o <= 1'b1;
      wr_o <= w;
      rd_o <= ~w;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      cs_o <= 1'b0;
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask : cycle

   task automatic wr_reg(input logic [2:0] a, input itmr_pkg::itmr_word_t d);
      itmr_pkg::itmr_word_t v;
      v = d;
      if (a == `ITMR_OFS_FLAGS) v = v & 16'h0003;
      if (a == `ITMR_OFS_CTRL) v = v & 16'h000f;
      if (a == `ITMR_OFS_CTRL && v[`ITMR_CTL_STOP]) v[`ITMR_CTL_START] = 1'b0;
      cycle(1'b1, a, v);
   endtask : wr_reg

   // read data lands on the taking edge; sample it just after
   task automatic rd_reg(input logic [2:0] a, output itmr_pkg::itmr_word_t d);
      cycle(1'b0, a, wdata_o);
      #1;
      d = rdata_i;
   endtask : rd_reg
endmodule : itmr_master

// >>> itmr_pkg.sv
// Purpose: types shared by the interval timer modules
// Assumes: constants live in itmr_consts.svh
// Notes: nothing here is imported; users write itmr_pkg::name
package itmr_pkg;

   // ----------------------------------------------------------------
   // data types
   // ----------------------------------------------------------------
   typedef logic [15:0] itmr_word_t;
   typedef logic [31:0] itmr_cnt_t;

   // command from the register file to the counter
   typedef struct packed {
      logic load;
      itmr_cnt_t load_val;
      logic start;
      logic halt;
   } itmr_cmd_s;

   // counter state
   typedef struct packed {
      itmr_cnt_t count;
      logic run;
   } itmr_cnt_st_s;

   // register file state
   typedef struct packed {
      logic to;
      logic ien;
      logic continuous_mode;
      itmr_cnt_t reload;
      itmr_cnt_t capture;
      itmr_word_t rdata;
      logic irq;
   } itmr_regs_s;

endpackage : itmr_pkg

// >>> itmr_timer.sv
// Purpose: interval timer register file and counter control
// Assumes: word-addressed slave port, reads answer one cycle later
// Notes: STOPCTL_EN selects whether software may start and halt the counter
//
// Functional notes
// - six 16-bit word registers decoded at offsets 0 to 5.
// - timeout flag sets when counter hits zero, stays until cleared.
// - writing zero to flags clears the timeout flag.
// - flags bit 1 reads one while counting, zero while stopped.
// - running bit is read-only; flags writes leave it alone.
// - interrupt only while enable bit and timeout flag are both set.
// - continuous mode keeps running through zero; otherwise stop at zero.
// - every zero reloads the counter from the 32-bit reload value.
// - start bit resumes a stopped counter from its present count.
// - halt bit stops a running counter; zero does nothing.
// - without run control, halt is ignored and counting never stops.
// - reload registers hold low and high halves of period minus one.
// - capture registers return low and high halves of last capture.
// - reload register write loads counter and halts it if controllable.
// - capture register write copies whole count, counter undisturbed.
// - counter sits at zero one cycle before reloading.
`include "itmr_consts.svh"

module itmr_timer #(
   parameter bit STOPCTL_EN = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cs_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [2:0] addr_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   localparam itmr_pkg::itmr_regs_s RST_REGS = '{
      to: 1'b0,
      ien: 1'b0,
      continuous_mode: 1'b0,
      reload: `ITMR_RELOAD_RST,
      capture: `ITMR_CAPTURE_RST,
      rdata: `ITMR_WORD_RST,
      irq: 1'b0
   };

   itmr_pkg::itmr_regs_s st_q;
   itmr_pkg::itmr_regs_s st_d;
   itmr_pkg::itmr_cmd_s cmd;
   itmr_pkg::itmr_cnt_st_s cnt_st;
   logic zero_hit;
   logic wr_flags;
   logic wr_ctrl;
   logic wr_rld;
   logic wr_cap;
   logic rd_req;
   itmr_pkg::itmr_cnt_t reload_new;

   // selected write strobe for one offset
   function automatic logic wr_hit(input logic cs, input logic wr, input logic [2:0] addr,
                                   input logic [2:0] ofs);
      wr_hit = cs && wr && (addr == ofs);
   endfunction : wr_hit

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // write decode
   assign wr_flags = wr_hit(cs_i, wr_i, addr_i, `ITMR_OFS_FLAGS);
   assign wr_ctrl = wr_hit(cs_i, wr_i, addr_i, `ITMR_OFS_CTRL);
   assign wr_rld = wr_hit(cs_i, wr_i, addr_i, `ITMR_OFS_RLDL) ||
                   wr_hit(cs_i, wr_i, addr_i, `ITMR_OFS_RLDH);
   assign wr_cap = wr_hit(cs_i, wr_i, addr_i, `ITMR_OFS_CAPL) ||
                   wr_hit(cs_i, wr_i, addr_i, `ITMR_OFS_CAPH);
   assign rd_req = cs_i && rd_i;

   // ----------------------------------------------------------------
   // counter commands
   // ----------------------------------------------------------------
   // reload halves merged with the word being written
   always_comb begin
      reload_new = st_q.reload;
      if (wr_hit(cs_i, wr_i, addr_i, `ITMR_OFS_RLDL)) begin
         reload_new[15:0] = wdata_i;
      end
      if (wr_hit(cs_i, wr_i, addr_i, `ITMR_OFS_RLDH)) begin
         reload_new[31:16] = wdata_i;
      end
   end

   // control and reload writes become one-cycle counter commands
   always_comb begin
      cmd.load_val = reload_new;
      cmd.load = wr_rld;
      cmd.start = wr_ctrl && wdata_i[`ITMR_CTL_START];
      // halt request, also from a reload write
      cmd.halt = (wr_ctrl && wdata_i[`ITMR_CTL_STOP]) || wr_rld;
   end

   // halt wins when both are set
   // counter runs in its own module
   itmr_counter #(
      .STOPCTL_EN(STOPCTL_EN)
   ) u_counter (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cmd_i(cmd),
      .continuous_mode_i(st_q.continuous_mode),
      .reload_i(st_q.reload),
      .st_o(cnt_st),
      .zero_o(zero_hit)
   );

   // ----------------------------------------------------------------
   // register file next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      // flags write with zero clears timeout
      if (wr_flags && !wdata_i[`ITMR_FLG_TO]) begin
         st_d.to = 1'b0;
      end
      // zero sets timeout, set beats clear
      if (zero_hit) begin
         st_d.to = 1'b1;
      end
      // control bits that are stored
      if (wr_ctrl) begin
         st_d.ien = wdata_i[`ITMR_CTL_IEN];
         st_d.continuous_mode = wdata_i[`ITMR_CTL_CONTINUOUS_MODE];
      end
      st_d.reload = reload_new;
      // coherent capture of the full count
      if (wr_cap) begin
         st_d.capture = cnt_st.count;
      end
      // read mux, reserved bits read zero
      if (rd_req) begin
         st_d.rdata = `ITMR_WORD_RST;
         unique case (addr_i)
            `ITMR_OFS_FLAGS: begin
               st_d.rdata[`ITMR_FLG_TO] = st_q.to;
               // run bit lives in the counter, out of reach of flags writes
               st_d.rdata[`ITMR_FLG_RUN] = cnt_st.run;
            end
            `ITMR_OFS_CTRL: begin
               st_d.rdata[`ITMR_CTL_IEN] = st_q.ien;
               st_d.rdata[`ITMR_CTL_CONTINUOUS_MODE] = st_q.continuous_mode;
            end
            `ITMR_OFS_RLDL: st_d.rdata = st_q.reload[15:0];
            `ITMR_OFS_RLDH: st_d.rdata = st_q.reload[31:16];
            `ITMR_OFS_CAPL: st_d.rdata = st_q.capture[15:0];
            `ITMR_OFS_CAPH: st_d.rdata = st_q.capture[31:16];
            default: st_d.rdata = `ITMR_WORD_RST; // unmapped words
         endcase
      end
      st_d.irq = st_d.ien && st_d.to;
   end

   // state register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= RST_REGS;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata_o = st_q.rdata;
   assign irq_o = st_q.irq;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // counter sitting at one with nothing loading
   sequence s_last_tick;
      cnt_st.run && (cnt_st.count == `ITMR_CNT_ONE) && !cmd.load && !cmd.halt;
   endsequence

   // zero cycle with nothing loading
   sequence s_zero_cycle;
      zero_hit && !cmd.load;
   endsequence

   // start request on a stopped counter
   sequence s_start_req;
      wr_ctrl && wdata_i[`ITMR_CTL_START] && !wdata_i[`ITMR_CTL_STOP] && !cnt_st.run;
   endsequence

   to_set_a: assert property (zero_hit |=> st_q.to)
      else $error("timeout flag not set after zero");

   to_sticky_a: assert property (st_q.to && !wr_flags |=> st_q.to)
      else $error("timeout flag dropped without a clear");

   to_clear_a: assert property (wr_flags && !wdata_i[`ITMR_FLG_TO] && !zero_hit |=> !st_q.to)
      else $error("timeout flag not cleared by flags write");

   run_read_a: assert property (rd_req && addr_i == `ITMR_OFS_FLAGS
                                |=> rdata_o[`ITMR_FLG_RUN] == $past(cnt_st.run))
      else $error("running bit reads wrong");

   run_keep_a: assert property (wr_flags && !zero_hit |=> cnt_st.run == $past(cnt_st.run))
      else $error("flags write changed running state");

   irq_gate_a: assert property (irq_o == (st_q.ien && st_q.to))
      else $error("interrupt does not match enable and flag");

   irq_off_a: assert property (!st_q.ien |-> !irq_o)
      else $error("interrupt raised while disabled");

   oneshot_stop_a: assert property (s_zero_cycle and (STOPCTL_EN && !st_q.continuous_mode)
                                    |=> !cnt_st.run)
      else $error("one-shot counter kept running");

   continuous_mode_run_a: assert property (s_zero_cycle and (st_q.continuous_mode && !cmd.halt) |=> cnt_st.run)
      else $error("continuous counter stopped at zero");

   zero_reload_a: assert property (s_zero_cycle |=> cnt_st.count == $past(st_q.reload))
      else $error("counter not reloaded at zero");

   zero_hold_a: assert property (s_last_tick ##1 (!cmd.load)
                                 |-> cnt_st.count == `ITMR_CNT_ZERO && cnt_st.run)
      else $error("counter skipped the zero cycle");

   start_run_a: assert property (s_start_req |=> cnt_st.run && cnt_st.count == $past(cnt_st.count))
      else $error("start did not resume the counter");

   halt_stop_a: assert property (wr_ctrl && wdata_i[`ITMR_CTL_STOP] && STOPCTL_EN |=> !cnt_st.run)
      else $error("halt did not stop the counter");

   free_run_a: assert property (!STOPCTL_EN |-> cnt_st.run)
      else $error("counter stopped without run control");

   rld_load_a: assert property (wr_rld |=> cnt_st.count == st_q.reload &&
                                (!STOPCTL_EN || !cnt_st.run))
      else $error("reload write did not load or halt");

   cap_copy_a: assert property (wr_cap |=> st_q.capture == $past(cnt_st.count))
      else $error("capture does not match counter");

   cap_read_a: assert property (rd_req && addr_i == `ITMR_OFS_CAPL
                                |=> rdata_o == $past(st_q.capture[15:0]))
      else $error("capture low reads wrong");

   dec_one_a: assert property (cnt_st.run && !zero_hit && !cmd.load
                               |=> cnt_st.count == $past(cnt_st.count) - `ITMR_CNT_ONE)
      else $error("counter did not drop by one");

   to_quiet_a: assert property (!st_q.to && !zero_hit |=> !st_q.to)
      else $error("timeout flag set without a zero");

   irq_clear_a: assert property (wr_flags && !wdata_i[`ITMR_FLG_TO] && !zero_hit
                                 |=> !irq_o)
      else $error("interrupt stayed after flags clear");

   irq_rise_a: assert property (zero_hit && st_q.ien && !wr_ctrl |=> irq_o)
      else $error("interrupt missing after timeout");

   unmapped_rd_a: assert property (rd_req && addr_i > `ITMR_OFS_CAPH
                                   |=> rdata_o == `ITMR_WORD_RST)
      else $error("unmapped offset read nonzero");

   rdata_hold_a: assert property (!rd_req |=> rdata_o == $past(rdata_o))
      else $error("read data changed without a read");

   ctrl_read_a: assert property (rd_req && addr_i == `ITMR_OFS_CTRL
                                 |=> rdata_o[`ITMR_CTL_IEN] == $past(st_q.ien) &&
                                 rdata_o[`ITMR_CTL_CONTINUOUS_MODE] == $past(st_q.continuous_mode))
      else $error("control reads wrong");

   rld_read_a: assert property (rd_req && addr_i == `ITMR_OFS_RLDH
                                |=> rdata_o == $past(st_q.reload[31:16]))
      else $error("reload high reads wrong");

   cap_high_a: assert property (rd_req && addr_i == `ITMR_OFS_CAPH
                                |=> rdata_o == $past(st_q.capture[31:16]))
      else $error("capture high reads wrong");

   cap_hold_a: assert property (!wr_cap |=> st_q.capture == $past(st_q.capture))
      else $error("capture changed without a write");

   cap_run_a: assert property (wr_cap && !zero_hit |=> cnt_st.run == $past(cnt_st.run))
      else $error("capture write changed running state");

   stop_hold_a: assert property (!cnt_st.run && !cmd.load
                                 |=> cnt_st.count == $past(cnt_st.count))
      else $error("stopped counter moved");

   halt_idle_a: assert property (wr_ctrl && wdata_i[`ITMR_CTL_STOP] && !cnt_st.run
                                 |=> !cnt_st.run && cnt_st.count == $past(cnt_st.count))
      else $error("halt disturbed a stopped counter");

   free_rld_a: assert property (wr_rld && !STOPCTL_EN |=> cnt_st.run)
      else $error("reload write stopped a free running counter");

   irq_mask_a: assert property (wr_ctrl && !wdata_i[`ITMR_CTL_IEN] |=> !irq_o)
      else $error("interrupt kept after enable cleared");

endmodule : itmr_timer

// >>> testbench.sv
// Purpose: self-checking bench for the interval timer register file
// Assumes: master model drives the port to two builds, with and without stop control
// Notes: capture pairs are six cycles apart by construction of the bus tasks
`include "itmr_consts.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // clock, reset, wiring
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cs;
   logic wr;
   logic rd;
   logic [2:0] addr;
   itmr_pkg::itmr_word_t wdata;
   logic [15:0] rdata;
   logic irq;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [15:0] rdata_free;
   logic irq_free;
   // reset value of offsets 0 to 6, unmapped offset 6 included
   logic [15:0] rst_exp [7] = '{16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000,
      16'h0000, 16'h0000};

   always #4 clk = ~clk;

   // free cycle count for period measurement
   always @(posedge clk) cyc <= cyc + 1;

   itmr_timer #(.STOPCTL_EN(1'b1)) u_dut (.clk_i(clk), .rst_i(rst), .cs_i(cs), .wr_i(wr),
      .rd_i(rd), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .irq_o(irq));

   itmr_master u_mst (.clk_i(clk), .cs_o(cs), .wr_o(wr), .rd_o(rd), .addr_o(addr),
      .wdata_o(wdata), .rdata_i(rdata));

   // second build without run control shares the bus
   itmr_timer #(.STOPCTL_EN(1'b0)) u_dut_free (.clk_i(clk), .rst_i(rst), .cs_i(cs), .wr_i(wr),
      .rd_i(rd), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata_free), .irq_o(irq_free));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   // capture then read both halves
   task automatic capture(output itmr_pkg::itmr_cnt_t v);
      itmr_pkg::itmr_word_t lo;
      itmr_pkg::itmr_word_t hi;
      u_mst.wr_reg(`ITMR_OFS_CAPL, 16'h0000);
      u_mst.rd_reg(`ITMR_OFS_CAPL, lo);
      u_mst.rd_reg(`ITMR_OFS_CAPH, hi);
      v = {hi, lo};
   endtask : capture

   task automatic rd_chk(input string what, input logic [2:0] a, input logic [15:0] exp);
      itmr_pkg::itmr_word_t d;
      u_mst.rd_reg(a, d);
      chk(what, {16'h0000, exp}, {16'h0000, d});
   endtask : rd_chk

   // bounded wait for the interrupt, returns the cycle it was seen
   task automatic wait_irq(output int t);
      t = -1;
      for (int i = 0; i < 200; i++) begin
         @(posedge clk);
         #1;
         if (irq === 1'b1) begin
            t = cyc;
            break;
         end
      end
      chk("irq seen", 1, t >= 0);
   endtask : wait_irq

   // watchdog cuts a hang short
   initial begin
      #100us;
      n_fail++;
      wrap_up();
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      itmr_pkg::itmr_word_t d;
      itmr_pkg::itmr_cnt_t c0;
      itmr_pkg::itmr_cnt_t c1;
      int t0;
      int t1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // reset values of offsets 0 to 6, unmapped offset 6 included
      for (int i = 0; i < 7; i++) begin
         rd_chk("reset read", 3'(i), rst_exp[i]);
      end
      u_mst.wr_reg(3'h6, 16'hffff);
      rd_chk("unmapped", 3'h6, 16'h0000);
      // split reload loads and halts
      u_mst.wr_reg(`ITMR_OFS_RLDH, 16'h0001);
      u_mst.wr_reg(`ITMR_OFS_RLDL, 16'h0000);
      rd_chk("flags after load", `ITMR_OFS_FLAGS, 16'h0000);
      chk("free after load", 32'h0000_0002, {16'h0000, rdata_free});
      capture(c0);
      chk("loaded count", 32'h0001_0000, c0);
      // running: one count per cycle, capture leaves it alone
      u_mst.wr_reg(`ITMR_OFS_CTRL, 16'h0004);
      rd_chk("flags running", `ITMR_OFS_FLAGS, 16'h0002);
      capture(c0);
      capture(c1);
      chk("count step", 32'h0000_0006, c0 - c1);
      // halt freezes the count, start resumes from it
      u_mst.wr_reg(`ITMR_OFS_CTRL, 16'h0008);
      rd_chk("flags halted", `ITMR_OFS_FLAGS, 16'h0000);
      chk("free after halt", 32'h0000_0002, {16'h0000, rdata_free});
      capture(c0);
      capture(c1);
      chk("halted count", c0, c1);
      u_mst.wr_reg(`ITMR_OFS_CTRL, 16'h0004);
      capture(c1);
      chk("resumed count", 1, (c1 < c0) && (c1 > c0 - 32'h8));
      // continuous period is reload plus one
      u_mst.wr_reg(`ITMR_OFS_RLDH, 16'h0000);
      u_mst.wr_reg(`ITMR_OFS_RLDL, 16'h0014);
      rd_chk("flags reload", `ITMR_OFS_FLAGS, 16'h0000);
      u_mst.wr_reg(`ITMR_OFS_CTRL, 16'h0007);
      rd_chk("ctrl readback", `ITMR_OFS_CTRL, 16'h0003);
      wait_irq(t0);
      u_mst.wr_reg(`ITMR_OFS_FLAGS, 16'h0000);
      @(posedge clk);
      #1;
      chk("irq cleared", 1'b0, irq);
      wait_irq(t1);
      chk("period", 21, t1 - t0);
      rd_chk("flags continuous_mode", `ITMR_OFS_FLAGS, 16'h0003);
      u_mst.wr_reg(`ITMR_OFS_FLAGS, 16'h0001);
      rd_chk("flags kept", `ITMR_OFS_FLAGS, 16'h0003);
      u_mst.wr_reg(`ITMR_OFS_CTRL, 16'h0008);
      @(posedge clk);
      #1;
      chk("irq disabled", 1'b0, irq);
      u_mst.wr_reg(`ITMR_OFS_FLAGS, 16'h0000);
      // one-shot stops reloaded at the reload value, the period minus one
      u_mst.wr_reg(`ITMR_OFS_RLDL, 16'h0005);
      u_mst.wr_reg(`ITMR_OFS_CTRL, 16'h0005);
      wait_irq(t0);
      rd_chk("flags one-shot", `ITMR_OFS_FLAGS, 16'h0001);
      capture(c0);
      chk("reloaded count", 32'h0000_0005, c0);
      u_mst.wr_reg(`ITMR_OFS_FLAGS, 16'h0002);
      rd_chk("flags written", `ITMR_OFS_FLAGS, 16'h0000);
      // timeout with the enable off raises no interrupt
      u_mst.wr_reg(`ITMR_OFS_CTRL, 16'h0004);
      for (int i = 0; i < 10; i++) begin
         u_mst.rd_reg(`ITMR_OFS_FLAGS, d);
         if (d[`ITMR_FLG_TO] === 1'b1) break;
      end
      chk("flags masked", 16'h0001, d);
      chk("irq masked", 1'b0, irq);
      chk("free irq masked", 1'b0, irq_free);
      wrap_up();
   end
endmodule : testbench
